/* rtl/aspd_pkg.sv */
package aspd_pkg;

    // ==================================================================
    // Register indices on the serial port
    localparam logic [3:0] REG_ANALOG_CONTROL = 4'h2;
    localparam logic [3:0] REG_PIN_VALUE      = 4'h4;
    localparam logic [3:0] REG_PIN_DIR        = 4'h5;
    localparam logic [3:0] REG_PIN_FUNCTION   = 4'h6;
    localparam logic [3:0] REG_RESULT_HI      = 4'hD;
    localparam logic [3:0] REG_RESULT_MID     = 4'hE;
    localparam logic [3:0] REG_RESULT_LO      = 4'hF;

    // ==================================================================
    // Analog control fields and reset values
    localparam int         CTL_READY_BIT     = 7;
    localparam int         CTL_SPEED_BIT     = 5;
    localparam int         CTL_LSB_FIRST_BIT = 3;
    localparam logic [6:0] CTL_RESET         = 7'h00;
    localparam logic [7:0] PIN_VALUE_RESET   = 8'h00;
    localparam logic [7:0] PIN_DIR_RESET     = 8'hFF;
    localparam logic [7:0] PIN_FUNC_RESET    = 8'h00;

    // ==================================================================
    // Command bytes
    localparam logic [7:0] CMD_READ_RESULT         = 8'h01;
    localparam logic [7:0] CONTINUOUS_READ_CMD     = 8'h03;
    localparam logic [7:0] STOP_CONTINUOUS_CMD     = 8'h0F;
    localparam logic [3:0] CMD_READ_REG_HI         = 4'h1;
    localparam logic [3:0] CMD_WRITE_REG_HI        = 4'h5;
    localparam logic [7:0] FILTER_SYNC_CMD         = 8'hFC;
    localparam logic [7:0] CMD_CHIP_RESET          = 8'hFE;

    // ==================================================================
    // Timing
    localparam int NOMINAL_MCLK_HZ = 2457600;
    localparam int BASE_RATE_HZ    = 15;
    localparam int BASE_DECIM      = NOMINAL_MCLK_HZ / BASE_RATE_HZ;
    localparam int STALE_PULSES    = 3;
    localparam int RESULT_BITS     = 24;
    localparam int BYTE_BITS       = 8;

    typedef enum logic {
        LK_CMD,
        LK_WDATA
    } aspd_link_e;

    typedef struct packed {
        logic [7:0] func;
        logic [7:0] dir;
        logic [7:0] value;
        logic [6:0] ctl;
    } aspd_cfg_s;

endpackage : aspd_pkg

/* rtl/aspd_serial_port.sv */
`timescale 1ns/1ps

module aspd_serial_port
    import aspd_pkg::*;
#(
    parameter int DECIM_BASE = BASE_DECIM,
    parameter int PAT_PULSES = 4,
    parameter int PAT_HI_MIN = 3,
    parameter int PAT_HI_MAX = 6,
    parameter int PAT_LO_MAX = 8
) (
    // Clocks and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        sclk,
    // Serial link
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe_n,
    // Converter core
    input  wire logic [23:0] conv_word,
    input  wire logic        conv_valid,
    output logic             conversion_ready_n,
    output logic             conv_start,
    output logic [1:0]       rate_sel,
    output logic             mod_speed,
    output logic             filter_reset,
    output logic             mod_reset,
    output logic             mod_resync,
    output logic             chip_reset,
    // Dual-purpose pins
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe_n,
    output logic [7:0]       pin_is_data
);

    // ==================================================================
    // System domain: reset sources
    logic        chip_rst_reg;
    logic        stale_rst_reg;
    logic        pat_hit_reg;
    logic        sys_rst;
    logic        link_arst;
    logic        rcmd_s1, rcmd_s2, rcmd_s3;
    logic        rst_tgl_reg;

    assign sys_rst   = rst | chip_rst_reg;
    // Chip select acts asynchronously: the link logic is held in reset while it is high
    assign link_arst = cs_n | chip_rst_reg | stale_rst_reg;

    always_ff @(posedge clk_sys) begin
        chip_rst_reg <= rst | pat_hit_reg | (rcmd_s2 ^ rcmd_s3);
    end
    assign chip_reset = chip_rst_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {rcmd_s1, rcmd_s2, rcmd_s3} <= 3'b000;
        end else begin
            {rcmd_s1, rcmd_s2, rcmd_s3} <= {rst_tgl_reg, rcmd_s1, rcmd_s2};
        end
    end

    // ==================================================================
    // Reset pattern matcher on the serial clock line
    logic        sck_s1, sck_s2, sck_s3;
    logic [15:0] hi_cnt, lo_cnt;
    logic [7:0]  pat_cnt;
    logic        hi_ok;

    assign hi_ok = (hi_cnt >= 16'(PAT_HI_MIN)) && (hi_cnt <= 16'(PAT_HI_MAX));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {sck_s1, sck_s2, sck_s3} <= 3'b000;
            hi_cnt      <= 16'h0000;
            lo_cnt      <= 16'h0000;
            pat_cnt     <= 8'h00;
            pat_hit_reg <= 1'b0;
        end else begin
            {sck_s1, sck_s2, sck_s3} <= {sclk, sck_s1, sck_s2};
            pat_hit_reg <= 1'b0;
            if (sck_s2) begin
                hi_cnt <= (hi_cnt == 16'hFFFF) ? hi_cnt : hi_cnt + 16'h0001;
                lo_cnt <= 16'h0000;
            end else begin
                lo_cnt <= (lo_cnt == 16'hFFFF) ? lo_cnt : lo_cnt + 16'h0001;
                hi_cnt <= 16'h0000;
                if (lo_cnt > 16'(PAT_LO_MAX)) begin
                    pat_cnt <= 8'h00;
                end
            end
            if (sck_s3 && !sck_s2) begin
                if (!hi_ok) begin
                    pat_cnt <= 8'h00;
                end else if (pat_cnt == 8'(PAT_PULSES - 1)) begin
                    pat_cnt     <= 8'h00;
                    pat_hit_reg <= 1'b1;
                end else begin
                    pat_cnt <= pat_cnt + 8'h01;
                end
            end
        end
    end

    // ==================================================================
    // Idle watchdog: ready pulses with no serial clock activity
    logic       act_flag;
    logic       act_s1, act_s2;
    logic       act_clr_reg;
    logic       rdy_prev;
    logic [1:0] stale_cnt;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {act_s1, act_s2} <= 2'b00;
            // Holding the clear keeps the activity flag known through reset
            act_clr_reg      <= 1'b1;
            rdy_prev         <= 1'b1;
            stale_cnt        <= 2'b00;
            stale_rst_reg    <= 1'b0;
        end else begin
            {act_s1, act_s2} <= {act_flag, act_s1};
            act_clr_reg      <= act_s2;
            rdy_prev         <= conversion_ready_n;
            stale_rst_reg    <= 1'b0;
            if (act_s2) begin
                stale_cnt <= 2'b00;
            end else if (rdy_prev && !conversion_ready_n) begin
                if (stale_cnt == 2'(STALE_PULSES - 1)) begin
                    stale_cnt     <= 2'b00;
                    stale_rst_reg <= 1'b1;
                end else begin
                    stale_cnt <= stale_cnt + 2'b01;
                end
            end
        end
    end

    // ==================================================================
    // Result update and ready flag
    logic [23:0] hold_word, result_reg;
    logic        upd_pend, upd_wr;
    logic        rd_s1, rd_s2, rd_s3;
    logic        rd_tgl_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hold_word          <= 24'h00_0000;
            result_reg         <= 24'h00_0000;
            upd_pend           <= 1'b0;
            upd_wr             <= 1'b0;
            conversion_ready_n <= 1'b1;
            {rd_s1, rd_s2, rd_s3} <= 3'b000;
        end else begin
            {rd_s1, rd_s2, rd_s3} <= {rd_tgl_reg, rd_s1, rd_s2};
            upd_pend <= conv_valid;
            upd_wr   <= upd_pend;
            if (conv_valid) begin
                hold_word          <= conv_word;
                conversion_ready_n <= 1'b1;
            end else if (upd_wr) begin
                conversion_ready_n <= 1'b0;
            end else if (rd_s2 ^ rd_s3) begin
                conversion_ready_n <= 1'b1;
            end
            if (upd_pend) begin
                result_reg <= hold_word;
            end
        end
    end

    // ==================================================================
    // Configuration crossing and conversion timing
    aspd_cfg_s   cfg_link, cfg_s1, cfg_s2;
    logic [23:0] decim_cnt;
    logic [23:0] decim_top;
    logic [1:0]  rate_eff;

    // Reserved rate code runs as the slowest rate
    assign rate_eff  = (cfg_s2.ctl[1:0] == 2'b11) ? 2'b10 : cfg_s2.ctl[1:0];
    assign decim_top = 24'((DECIM_BASE << (rate_eff + {1'b0, cfg_s2.ctl[CTL_SPEED_BIT]})) - 1);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_s1     <= '{func: PIN_FUNC_RESET, dir: PIN_DIR_RESET,
                            value: PIN_VALUE_RESET, ctl: CTL_RESET};
            cfg_s2     <= '{func: PIN_FUNC_RESET, dir: PIN_DIR_RESET,
                            value: PIN_VALUE_RESET, ctl: CTL_RESET};
            decim_cnt  <= 24'h00_0000;
            conv_start <= 1'b0;
            rate_sel   <= 2'b00;
            mod_speed  <= 1'b0;
        end else begin
            cfg_s1    <= cfg_link;
            cfg_s2    <= cfg_s1;
            rate_sel  <= rate_eff;
            mod_speed <= cfg_s2.ctl[CTL_SPEED_BIT];
            // Counting master clock cycles makes the rate track that clock
            conv_start <= (decim_cnt >= decim_top);
            decim_cnt  <= (decim_cnt >= decim_top || mod_reset) ? 24'h00_0000
                                                               : decim_cnt + 24'h00_0001;
        end
    end

    // ==================================================================
    // Filter synchronisation
    logic ds_s1, ds_s2, ds_s3;
    logic mh_s1, mh_s2;
    logic fsync_tgl_reg, mod_hold_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {ds_s1, ds_s2, ds_s3} <= 3'b000;
            {mh_s1, mh_s2}        <= 2'b00;
            filter_reset          <= 1'b0;
            mod_reset             <= 1'b0;
            mod_resync            <= 1'b0;
        end else begin
            {ds_s1, ds_s2, ds_s3} <= {fsync_tgl_reg, ds_s1, ds_s2};
            {mh_s1, mh_s2}        <= {mod_hold_reg, mh_s1};
            filter_reset <= ds_s2 ^ ds_s3;
            mod_reset    <= mh_s2;
            mod_resync   <= mod_reset & ~mh_s2;
        end
    end

    // ==================================================================
    // Dual-purpose pins
    logic [7:0] pin_s1, pin_s2, pin_rd;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {pin_s1, pin_s2} <= 16'h0000;
        end else begin
            {pin_s1, pin_s2} <= {pin_in, pin_s1};
        end
    end

    // Analog path is never gated, so a driven data pin can still be converted
    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                pin_is_data[i] <= 1'b0;
                pin_out[i]     <= 1'b0;
                pin_oe_n[i]    <= 1'b1;
                pin_rd[i]      <= 1'b0;
            end else begin
                pin_is_data[i] <= cfg_s2.func[i];
                pin_out[i]     <= cfg_s2.value[i];
                pin_oe_n[i]    <= ~(cfg_s2.func[i] & ~cfg_s2.dir[i]);
                pin_rd[i]      <= !cfg_s2.func[i] ? 1'b0 :
                                  (cfg_s2.dir[i] ? pin_s2[i] : cfg_s2.value[i]);
            end
        end
    end

    // ==================================================================
    // Link domain: slave shift logic on the serial clock
    aspd_link_e link_st;
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic [3:0] wr_idx;
    logic [23:0] tx_sh;
    logic [4:0] tx_left;
    logic       tx_result;
    logic       cont_mode, word_taken;
    logic [7:0] rx_byte, rd_val;
    logic [6:0] ctl_reg;
    logic [7:0] value_reg, dir_reg, func_reg;
    logic [7:0] pinrd_l1, pinrd_l2;
    logic       rdy_l1, rdy_l2;
    logic       byte_done, cmd_ok, load_res, load_reg, do_wr, do_fsync, stop_hit;
    logic [23:0] res_ord;

    assign rx_byte   = {rx_sh, din};
    assign byte_done = (bit_cnt == 3'd7);
    assign cmd_ok    = byte_done && (link_st == LK_CMD) && (tx_left == 5'd0) && !cont_mode;
    assign stop_hit  = byte_done && cont_mode &&
                       (rx_byte == STOP_CONTINUOUS_CMD || rx_byte == CMD_CHIP_RESET);
    assign load_res  = (cmd_ok && rx_byte == CMD_READ_RESULT) ||
                       (byte_done && cont_mode && !stop_hit && !rdy_l2 && !word_taken &&
                        tx_left == 5'd0);
    assign load_reg  = cmd_ok && rx_byte[7:4] == CMD_READ_REG_HI;
    assign do_wr     = byte_done && (link_st == LK_WDATA);
    assign do_fsync  = cmd_ok && rx_byte == FILTER_SYNC_CMD;
    assign res_ord   = ctl_reg[CTL_LSB_FIRST_BIT] ? {<<{result_reg}} : result_reg;
    assign cfg_link  = '{func: func_reg, dir: dir_reg, value: value_reg, ctl: ctl_reg};

    always_comb begin
        case (rx_byte[3:0])
            REG_ANALOG_CONTROL: rd_val = {rdy_l2, ctl_reg};
            REG_PIN_VALUE:      rd_val = pinrd_l2;
            REG_PIN_DIR:        rd_val = dir_reg;
            REG_PIN_FUNCTION:   rd_val = func_reg;
            REG_RESULT_HI:      rd_val = result_reg[23:16];
            REG_RESULT_MID:     rd_val = result_reg[15:8];
            REG_RESULT_LO:      rd_val = result_reg[7:0];
            default:            rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge sclk or posedge link_arst) begin
        if (link_arst) begin
            link_st <= LK_CMD;
            bit_cnt <= 3'd0;
            rx_sh   <= 7'h00;
            wr_idx  <= 4'h0;
            tx_sh   <= 24'h00_0000;
            tx_left <= 5'd0;
        end else begin
            rx_sh   <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'd1;
            if (tx_left != 5'd0) begin
                tx_sh   <= {tx_sh[22:0], 1'b0};
                tx_left <= tx_left - 5'd1;
            end
            if (load_res) begin
                tx_sh   <= res_ord;
                tx_left <= 5'(RESULT_BITS);
            end else if (load_reg) begin
                tx_sh   <= {rd_val, 16'h0000};
                tx_left <= 5'(BYTE_BITS);
            end
            if (cmd_ok && rx_byte[7:4] == CMD_WRITE_REG_HI) begin
                link_st <= LK_WDATA;
                wr_idx  <= rx_byte[3:0];
            end else if (do_wr) begin
                link_st <= LK_CMD;
            end
        end
    end

    // Output stage changes on the falling edge, ahead of the sampling edge
    always_ff @(negedge sclk or posedge link_arst) begin
        if (link_arst) begin
            dout      <= 1'b0;
            dout_oe_n <= 1'b1;
        end else begin
            dout      <= tx_sh[23];
            dout_oe_n <= (tx_left == 5'd0);
        end
    end

    // Activity marker, cleared from the system side once seen
    always_ff @(posedge sclk or posedge act_clr_reg) begin
        if (act_clr_reg) begin
            act_flag <= 1'b0;
        end else begin
            act_flag <= 1'b1;
        end
    end

    // Mode, registers and event toggles survive chip select
    always_ff @(posedge sclk or posedge chip_rst_reg) begin
        if (chip_rst_reg) begin
            cont_mode     <= 1'b0;
            word_taken    <= 1'b0;
            tx_result     <= 1'b0;
            rd_tgl_reg    <= 1'b0;
            fsync_tgl_reg <= 1'b0;
            rst_tgl_reg   <= 1'b0;
            mod_hold_reg  <= 1'b0;
            ctl_reg       <= CTL_RESET;
            value_reg     <= PIN_VALUE_RESET;
            dir_reg       <= PIN_DIR_RESET;
            func_reg      <= PIN_FUNC_RESET;
            {pinrd_l1, pinrd_l2} <= 16'h0000;
            {rdy_l1, rdy_l2}     <= 2'b11;
        end else begin
            {pinrd_l1, pinrd_l2} <= {pin_rd, pinrd_l1};
            {rdy_l1, rdy_l2}     <= {conversion_ready_n, rdy_l1};
            mod_hold_reg <= do_fsync;
            if (stop_hit) begin
                cont_mode <= 1'b0;
            end else if (cmd_ok && rx_byte == CONTINUOUS_READ_CMD) begin
                cont_mode <= 1'b1;
            end
            if (load_res) begin
                tx_result  <= 1'b1;
                word_taken <= 1'b1;
            end else if (rdy_l2) begin
                word_taken <= 1'b0;
            end
            if (tx_result && tx_left == 5'd1) begin
                rd_tgl_reg <= ~rd_tgl_reg;
                tx_result  <= 1'b0;
            end
            if (do_fsync) begin
                fsync_tgl_reg <= ~fsync_tgl_reg;
            end
            if ((cmd_ok || stop_hit) && rx_byte == CMD_CHIP_RESET) begin
                rst_tgl_reg <= ~rst_tgl_reg;
            end
            if (do_wr) begin
                case (wr_idx)
                    REG_ANALOG_CONTROL: ctl_reg   <= rx_byte[6:0];
                    REG_PIN_VALUE:      value_reg <= rx_byte;
                    REG_PIN_DIR:        dir_reg   <= rx_byte;
                    REG_PIN_FUNCTION:   func_reg  <= rx_byte;
                    default:            ;
                endcase
            end
        end
    end

endmodule : aspd_serial_port

/* dv/aspd_serial_port_asserts.sv */
`timescale 1ns/1ps
module aspd_serial_port_asserts (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Link and core
    input wire logic       cs_n,
    input wire logic       dout_oe_n,
    input wire logic       conv_valid,
    input wire logic       conversion_ready_n,
    input wire logic       conv_start,
    input wire logic [1:0] rate_sel,
    input wire logic       filter_reset,
    input wire logic       mod_reset,
    input wire logic       mod_resync,
    input wire logic       chip_reset,
    // Pins
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_is_data
);
    // ==================================================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_ready_cycle;
        conv_valid |=> conversion_ready_n ##2 !conversion_ready_n;
    endproperty
    a_ready_cycle: assert property (p_ready_cycle)
        else $error("ready not cycled around result update");
    property p_ready_cause;
        $fell(conversion_ready_n) |-> $past(conv_valid, 3);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready fell without a new word");
    // Both sides deselected a full cycle, so the async link reset has landed
    property p_dout_idle;
        cs_n && $past(cs_n) |-> dout_oe_n;
    endproperty
    a_dout_idle: assert property (p_dout_idle)
        else $error("data out driven while deselected");
    property p_resync_rel;
        $fell(mod_reset) |-> ##[0:2] mod_resync;
    endproperty
    a_resync_rel: assert property (p_resync_rel)
        else $error("no resync after modulator release");
    property p_resync_only;
        mod_resync |-> !mod_reset ##1 !mod_resync;
    endproperty
    a_resync_only: assert property (p_resync_only)
        else $error("resync while modulator held");
    property p_filter_pulse;
        filter_reset |=> !filter_reset;
    endproperty
    a_filter_pulse: assert property (p_filter_pulse)
        else $error("filter reset longer than one cycle");
    property p_pin_analog;
        (~pin_oe_n & ~pin_is_data) == 8'h00;
    endproperty
    a_pin_analog: assert property (p_pin_analog)
        else $error("analog pin driven");
    property p_rate_code;
        rate_sel != 2'b11;
    endproperty
    a_rate_code: assert property (p_rate_code)
        else $error("reserved rate code in use");
    property p_start_pulse;
        conv_start |=> !conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("conversion start longer than one cycle");

    c_conv: cover property (conv_valid);
    c_release: cover property ($fell(mod_reset));
    c_chip: cover property ($rose(chip_reset));
endmodule : aspd_serial_port_asserts

bind aspd_serial_port aspd_serial_port_asserts u_aspd_serial_port_asserts (
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .dout_oe_n(dout_oe_n),
    .conv_valid(conv_valid), .conversion_ready_n(conversion_ready_n),
    .conv_start(conv_start), .rate_sel(rate_sel), .filter_reset(filter_reset),
    .mod_reset(mod_reset), .mod_resync(mod_resync), .chip_reset(chip_reset),
    .pin_oe_n(pin_oe_n), .pin_is_data(pin_is_data));

/* dv/aspd_host_model.sv */
`timescale 1ns/1ps
module aspd_host_model (
    // Serial master, separate data lines
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe_n
);
    // ==================================================================
    // Clock parked low between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // Select moves only with the clock parked, possibly inside a byte
    task automatic sel(input logic lvl);
        #20;
        cs_n = lvl;
        #20;
    endtask : sel

    // A released data-out line reads as the inverse of its last bit
    task automatic shift(input int nb, input logic [23:0] tx, output logic [23:0] rx);
        rx = 24'h00_0000;
        for (int i = nb - 1; i >= 0; i--) begin
            din = tx[i];
            #16;
            sclk = 1'b1;
            rx = {rx[22:0], dout_oe_n ? ~rx[0] : dout};
            #16;
            sclk = 1'b0;
        end
        din = ~din;
    endtask : shift

    // Slow clock pulses for the chip reset pattern, select left high
    task automatic pulse(input int n);
        repeat (n) begin
            sclk = 1'b1;
            #1000;
            sclk = 1'b0;
            #500;
        end
    endtask : pulse
endmodule : aspd_host_model

/* dv/tb_adc_serial_port_dio.sv */
`timescale 1ns/1ps
module tb_adc_serial_port_dio import aspd_pkg::*; ;
    // ==================================================================
    // Signals
    logic        clk_sys, rst, conv_valid, dout, dout_oe_n, conversion_ready_n;
    logic        conv_start, mod_speed, filter_reset, mod_reset, mod_resync, chip_reset;
    logic [23:0] conv_word, rx;
    logic [7:0]  ext_lvl, pin_out, pin_oe_n, pin_is_data;
    logic [1:0]  rate_sel;
    wire  [7:0]  pin_in;
    wire         sclk, cs_n, din;
    int          err_count, n_compared, n;
    int          n_fr = 0;

    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);

    // Pattern widths sit above any streak the fast serial clock aliases to
    aspd_serial_port #(.DECIM_BASE(16), .PAT_HI_MIN(8), .PAT_HI_MAX(12)) u_aspd_serial_port (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe_n(dout_oe_n), .conv_word(conv_word),
        .conv_valid(conv_valid), .conversion_ready_n(conversion_ready_n),
        .conv_start(conv_start), .rate_sel(rate_sel), .mod_speed(mod_speed),
        .filter_reset(filter_reset), .mod_reset(mod_reset), .mod_resync(mod_resync),
        .chip_reset(chip_reset), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_is_data(pin_is_data));
    aspd_host_model u_aspd_host_model (
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (filter_reset === 1'b1) n_fr <= n_fr + 1;

    // ==================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic xf(input int nb, input logic [23:0] tx);
        u_aspd_host_model.shift(nb, tx, rx);
    endtask : xf
    task automatic rd(input logic [3:0] r, input logic [7:0] e);
        u_aspd_host_model.sel(1'b0);
        xf(8, {16'h0000, CMD_READ_REG_HI, r});
        xf(8, 24'h00_0000);
        u_aspd_host_model.sel(1'b1);
        chk(rx[7:0], e);
    endtask : rd
    task automatic wr(input logic [3:0] r, input logic [7:0] v);
        u_aspd_host_model.sel(1'b0);
        xf(8, {16'h0000, CMD_WRITE_REG_HI, r});
        xf(8, {16'h0000, v});
        u_aspd_host_model.sel(1'b1);
        repeat (4) @(posedge clk_sys);
    endtask : wr
    task automatic conv(input logic [23:0] w);
        @(posedge clk_sys);
        conv_valid <= 1'b1;
        conv_word  <= w;
        @(posedge clk_sys);
        conv_valid <= 1'b0;
        repeat (5) @(posedge clk_sys);
    endtask : conv
    task automatic rres(input logic [23:0] e);
        u_aspd_host_model.sel(1'b0);
        xf(8, {16'h0000, CMD_READ_RESULT});
        xf(24, 24'h00_0000);
        u_aspd_host_model.sel(1'b1);
        chk(rx, e);
    endtask : rres
    task automatic wait_start(output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while (conv_start !== 1'b1 && c < 4000);
        if (c >= 4000) begin
            err_count++;
            close_out();
        end
    endtask : wait_start

    // ==================================================================
    // Sequence
    initial begin
        rst        = 1'b1;
        conv_valid = 1'b0;
        conv_word  = 24'h00_0000;
        ext_lvl    = 8'h96;
        err_count  = 0;
        n_compared = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(REG_PIN_FUNCTION, 8'h00);
        rd(REG_PIN_DIR, 8'hFF);
        rd(REG_ANALOG_CONTROL, 8'h80);
        wr(4'h3, 8'h55);
        rd(4'h3, 8'h00);
        wr(REG_PIN_FUNCTION, 8'h3C);
        wr(REG_PIN_DIR, 8'h0F);
        wr(REG_PIN_VALUE, 8'hA5);
        chk(pin_is_data, 8'h3C);
        chk(pin_oe_n, 8'hCF);
        chk(pin_out & 8'h30, 8'h20);
        rd(REG_PIN_VALUE, 8'h24);
        ext_lvl <= 8'h69;
        repeat (4) @(posedge clk_sys);
        rd(REG_PIN_VALUE, 8'h28);
        for (int r = 0; r < 4; r++) begin
            wr(REG_ANALOG_CONTROL, {2'b00, r == 3, 3'b000, 2'(r)});
            repeat (3) wait_start(n);
            chk(rate_sel, (r == 3) ? 2 : r);
            chk(mod_speed, r == 3);
            chk(n, 16 << ((r == 3) ? 3 : r));
        end
        wr(REG_ANALOG_CONTROL, 8'h00);
        conv(24'h12_3456);
        chk(conversion_ready_n, 1'b0);
        rd(REG_ANALOG_CONTROL, 8'h00);
        rres(24'h12_3456);
        repeat (6) @(posedge clk_sys);
        chk(conversion_ready_n, 1'b1);
        wr(REG_ANALOG_CONTROL, 8'h08);
        conv(24'h00_0001);
        rres(24'h80_0000);
        wr(REG_ANALOG_CONTROL, 8'h00);
        // Abandoned half byte must not shift the next frame
        u_aspd_host_model.sel(1'b0);
        xf(4, 24'h00_0005);
        u_aspd_host_model.sel(1'b1);
        rd(REG_PIN_FUNCTION, 8'h3C);
        u_aspd_host_model.sel(1'b0);
        xf(8, {16'h0000, CONTINUOUS_READ_CMD});
        conv(24'hAB_CDEF);
        xf(8, 24'h00_0000);
        xf(24, 24'h00_0000);
        chk(rx, 24'hAB_CDEF);
        xf(8, {16'h0000, STOP_CONTINUOUS_CMD});
        u_aspd_host_model.sel(1'b1);
        rd(REG_PIN_FUNCTION, 8'h3C);
        // Select held low throughout: only the idle watchdog can realign
        u_aspd_host_model.sel(1'b0);
        xf(4, 24'h00_0005);
        repeat (8) @(posedge clk_sys);
        repeat (3) conv(24'hFF_FFFF);
        xf(8, {16'h0000, CMD_READ_REG_HI, REG_PIN_FUNCTION});
        xf(8, 24'h00_0000);
        chk(rx[7:0], 8'h3C);
        xf(8, {16'h0000, FILTER_SYNC_CMD});
        repeat (8) @(posedge clk_sys);
        chk(mod_reset, 1'b1);
        chk(n_fr, 1);
        xf(1, 24'h00_0000);
        u_aspd_host_model.sel(1'b1);
        repeat (8) @(posedge clk_sys);
        chk(mod_reset, 1'b0);
        u_aspd_host_model.pulse(4);
        repeat (4) @(posedge clk_sys);
        rd(REG_PIN_FUNCTION, 8'h00);
        wr(REG_PIN_FUNCTION, 8'h3C);
        u_aspd_host_model.sel(1'b0);
        xf(8, {16'h0000, CMD_CHIP_RESET});
        u_aspd_host_model.sel(1'b1);
        repeat (10) @(posedge clk_sys);
        rd(REG_PIN_FUNCTION, 8'h00);
        rd(REG_ANALOG_CONTROL, 8'h80);
        close_out();
    end
endmodule : tb_adc_serial_port_dio
